// ---- hdl/serial_control_port.sv ----
`timescale 1ns/1ps
// Behaviour
// - Slave shifts in sixteen bit control word
// - Status word shifted out during frame
// - Data valid at falling serial clock
// - Both words move most significant first
// - Frame starts on select falling
// - Select rising executes shifted word
// - Output released after select rises
// - Shared bus works; no daisy chain, zeros follow status
// - Data, common fields, then two address bits
// - Control words hold until rewritten or reset
// - Select falling snapshots diagnostic status
// - Address zero holds lock heat stages
// - Address one holds first pwm routes
// - Address two holds mirror lamp stages
// - Address three holds second pwm routes
// - Low side bit switches stage
// - High side bit switches stage
// - First routing bits give first pin where second routing bits are clear
// - Second routing bits give second pin
// - Sense code picks stage or none
// - Clear request clears selected errors after frame
// - Address picks register and next status
module serial_control_port (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic serial_clock,
  input wire logic select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_en,
  input wire logic [15:0] status_word [4],
  input wire logic first_pwm_pin,
  input wire logic second_pwm_pin,
  output logic [5:0] low_side_drive,
  output logic [10:0] high_side_drive,
  output logic [2:0] sense_stage,
  output logic pullup_out7_enable,
  output logic pullup_out8_9_enable,
  output logic pullup_out10_11_enable,
  output logic [2:0] test_mode_bits,
  output logic [1:0] status_clear_request,
  output logic status_clear_valid
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic sclk;
    logic sel_n;
    logic [15:0] shift;
    logic [15:0] tx;
    logic [4:0] count;
    logic [9:0] lock_heat;
    logic [9:0] first_route;
    logic [9:0] mirror_lamp;
    logic [9:0] second_route;
    logic [2:0] sense_select;
    logic [1:0] status_sel;
    logic out_bit;
    logic clr;
    logic [1:0] clr_sel;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic fall;
  logic rise;
  logic sel_start;
  logic sel_end;
  logic [15:0] word;
  logic [5:0] low_side_on;
  logic [10:0] high_side_on;
  logic [7:0] pwm_first;
  logic [7:0] pwm_second;

  assign fall = st_r.sclk & ~serial_clock;
  assign rise = ~st_r.sclk & serial_clock;
  assign sel_start = st_r.sel_n & ~select_n;
  assign sel_end = ~st_r.sel_n & select_n;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    word = 16'h0000;
    st_nxt.sclk = serial_clock;
    st_nxt.sel_n = select_n;
    st_nxt.clr = 1'b0;
    if (sel_start) begin
      st_nxt.tx = status_word[st_r.status_sel];
      st_nxt.out_bit = status_word[st_r.status_sel][15];
      st_nxt.count = 5'h00;
    end else if (!select_n && !st_r.sel_n) begin
      if (fall) begin
        // Sample and shift on same edge: status moves out, zeros fill behind
        st_nxt.shift = {st_r.shift[14:0], serial_in};
        st_nxt.tx = {st_r.tx[14:0], 1'b0};
        if (st_r.count != 5'h10) begin
          st_nxt.count = st_r.count + 5'h01;
        end
      end
      if (rise) begin
        // New bit placed on the rising edge, stable for next falling one
        st_nxt.out_bit = st_r.tx[15];
      end
    end
    if (sel_end) begin
      word = st_r.shift;
      st_nxt.sense_select = word[frame_pkg::SENSE_LSB +: 3];
      st_nxt.status_sel = word[frame_pkg::ADDR_LSB +: 2];
      st_nxt.clr = word[frame_pkg::CLR_BIT];
      st_nxt.clr_sel = st_r.status_sel;
      unique case (word[1:0])
        frame_pkg::LOCK_HEAT_ADDR: st_nxt.lock_heat = word[15:6];
        frame_pkg::FIRST_ROUTE_ADDR: st_nxt.first_route = word[15:6];
        frame_pkg::MIRROR_LAMP_ADDR: st_nxt.mirror_lamp = word[15:6];
        frame_pkg::SECOND_ROUTE_ADDR: st_nxt.second_route = word[15:6];
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '{sclk: 1'b0, sel_n: 1'b1, shift: 16'h0000, tx: 16'h0000,
        count: 5'h00, lock_heat: frame_pkg::DATA_RESET,
        first_route: frame_pkg::DATA_RESET, mirror_lamp: frame_pkg::DATA_RESET,
        second_route: frame_pkg::DATA_RESET, sense_select: frame_pkg::SENSE_RESET,
        status_sel: frame_pkg::STATUS_SEL_RESET, out_bit: 1'b0, clr: 1'b0,
        clr_sel: 2'h0};
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  stage_map u_map (
    .lock_heat(st_r.lock_heat),
    .mirror_lamp(st_r.mirror_lamp),
    .sense_select(st_r.sense_select),
    .low_side_on(low_side_on),
    .high_side_on(high_side_on),
    .sense_stage(sense_stage)
  );

  // Route bits: [7:3] high side 7..11, [2:0] low side 1..3
  assign pwm_first = st_r.first_route[9:2];
  assign pwm_second = st_r.second_route[9:2];

  always_comb begin
    low_side_drive = low_side_on;
    high_side_drive = high_side_on;
    for (int i = 0; i < 3; i++) begin
      if (pwm_first[2 - i]) low_side_drive[i] = first_pwm_pin;
      if (pwm_second[2 - i]) low_side_drive[i] = second_pwm_pin;
    end
    for (int i = 0; i < 5; i++) begin
      if (pwm_first[7 - i]) high_side_drive[6 + i] = first_pwm_pin;
      if (pwm_second[7 - i]) high_side_drive[6 + i] = second_pwm_pin;
    end
  end

  assign pullup_out7_enable = st_r.first_route[1];
  assign pullup_out8_9_enable = st_r.second_route[1];
  assign pullup_out10_11_enable = st_r.second_route[0];
  // Test bits exported only; master keeps them zero
  assign test_mode_bits = st_r.lock_heat[2:0];
  assign status_clear_request = st_r.clr_sel;
  assign status_clear_valid = st_r.clr;
  assign serial_out = st_r.out_bit;
  assign serial_out_en = ~st_r.sel_n;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_out_release: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && sel_end |=> !serial_out_en) else $error("output not released");
  a_exec_addr: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && sel_end |=> st_r.status_sel == $past(st_r.shift[1:0]))
    else $error("address not taken");
  a_lock_write: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && sel_end && st_r.shift[1:0] == 2'h0 |=> st_r.lock_heat == $past(st_r.shift[15:6]))
    else $error("lock word not stored");
  a_hold_word: assert property (@(posedge clk) disable iff (sys_rst)
    !sel_end |=> $stable(st_r.mirror_lamp)) else $error("control word changed");
  a_idle_shift: assert property (@(posedge clk) disable iff (sys_rst)
    select_n && st_r.sel_n |=> $stable(st_r.shift)) else $error("shift while deselected");
  a_snap_status: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && sel_start |=> serial_out == $past(status_word[st_r.status_sel][15]))
    else $error("status not captured");
  a_clear_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && sel_end && st_r.shift[2] |=> status_clear_valid ##1 !status_clear_valid)
    else $error("clear pulse wrong");
  a_shift_in: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && fall && !select_n && !st_r.sel_n |=> st_r.shift[0] == $past(serial_in))
    else $error("bit not shifted");
endmodule

// ---- hdl/frame_pkg.sv ----
package frame_pkg;
  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned ADDR_LSB = 0;
  localparam int unsigned CLR_BIT = 2;
  localparam int unsigned SENSE_LSB = 3;
  localparam int unsigned DATA_LSB = 6;
  localparam int unsigned DATA_BITS = 10;
  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [1:0] LOCK_HEAT_ADDR = 2'h0;
  localparam logic [1:0] FIRST_ROUTE_ADDR = 2'h1;
  localparam logic [1:0] MIRROR_LAMP_ADDR = 2'h2;
  localparam logic [1:0] SECOND_ROUTE_ADDR = 2'h3;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [9:0] DATA_RESET = 10'h000;
  localparam logic [2:0] SENSE_RESET = 3'h7;
  localparam logic [2:0] SENSE_NONE = 3'h7;
  localparam logic [3:0] BIT_COUNT_RESET = 4'h0;
  localparam logic [1:0] STATUS_SEL_RESET = 2'h0;
endpackage

// ---- hdl/stage_map.sv ----
`timescale 1ns/1ps
module stage_map (
  input wire logic [9:0] lock_heat,
  input wire logic [9:0] mirror_lamp,
  input wire logic [2:0] sense_select,
  output logic [5:0] low_side_on,
  output logic [10:0] high_side_on,
  output logic [2:0] sense_stage
);
  // ----------------------------------------
  // Stage on bits, index 0 is stage 1
  // ----------------------------------------
  always_comb begin
    low_side_on = {mirror_lamp[5], mirror_lamp[7], mirror_lamp[9], lock_heat[5],
      lock_heat[7], lock_heat[9]};
    high_side_on = {mirror_lamp[0], mirror_lamp[1], mirror_lamp[2], mirror_lamp[3],
      lock_heat[3], mirror_lamp[4], mirror_lamp[6], mirror_lamp[8], lock_heat[4],
      lock_heat[6], lock_heat[8]};
    // Encoded stage number, 0 means none
    unique case (sense_select)
      3'h0: sense_stage = 3'h1;
      3'h1: sense_stage = 3'h2;
      3'h2: sense_stage = 3'h3;
      3'h3: sense_stage = 3'h4;
      3'h4: sense_stage = 3'h7;
      default: sense_stage = 3'h0;
    endcase
  end
endmodule

// ---- sim/spi_master_model.sv ----
`timescale 1ns/1ps
module spi_master_model (
  input wire logic clk,
  output logic serial_clock,
  output logic select_n,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_en
);
  // ----------------------------------------
  // Idle bus: clock low, deselected
  // ----------------------------------------
  initial begin
    serial_clock = 1'b0;
    select_n = 1'b1;
    serial_in = 1'b0;
  end
  // Frame levels held three cycles, above the one-cycle minimum; stray pulses two
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    select_n = 1'b0;
    hold(3);
    for (int i = 15; i >= 0; i--) begin
      serial_in = tx[i];
      serial_clock = 1'b1;
      hold(3);
      // Released line reads inverted, so a stale bit never matches
      rx = {rx[14:0], serial_out_en ? serial_out : ~serial_out};
      serial_clock = 1'b0;
      hold(3);
    end
    select_n = 1'b1;
    serial_in = ~serial_in;
    hold(3);
  endtask
  task automatic stray(input int n);
    repeat (n) begin
      serial_clock = 1'b1;
      hold(2);
      serial_clock = 1'b0;
      hold(2);
    end
  endtask
endmodule

// ---- sim/spi_output_control_frame_bench.sv ----
`timescale 1ns/1ps
module spi_output_control_frame_bench;
  logic clk, sys_rst, serial_clock, select_n, serial_in, serial_out, serial_out_en;
  logic first_pwm_pin, second_pwm_pin, pullup_out7_enable, pullup_out8_9_enable;
  logic pullup_out10_11_enable, status_clear_valid;
  logic [15:0] status_word [4];
  logic [15:0] rx;
  logic [5:0] low_side_drive;
  logic [10:0] high_side_drive;
  logic [2:0] sense_stage, test_mode_bits;
  logic [1:0] status_clear_request;
  logic [1:0] clr_seen = 2'h2;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;
  serial_control_port dut (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .serial_clock(serial_clock), .select_n(select_n), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_en(serial_out_en), .status_word(status_word),
    .first_pwm_pin(first_pwm_pin), .second_pwm_pin(second_pwm_pin),
    .low_side_drive(low_side_drive), .high_side_drive(high_side_drive),
    .sense_stage(sense_stage), .pullup_out7_enable(pullup_out7_enable),
    .pullup_out8_9_enable(pullup_out8_9_enable),
    .pullup_out10_11_enable(pullup_out10_11_enable), .test_mode_bits(test_mode_bits),
    .status_clear_request(status_clear_request), .status_clear_valid(status_clear_valid));
  spi_master_model master (.clk(clk), .serial_clock(serial_clock), .select_n(select_n),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_en(serial_out_en));
  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic frame(input logic [15:0] tx, input logic [15:0] exp_rx);
    master.xfer(tx, rx);
    chk(rx, exp_rx);
    chk({15'h0, serial_out_en}, 16'h0);
  endtask
  task automatic outs(input logic [5:0] ls, input logic [10:0] hs, input logic [2:0] ss);
    chk({5'h0, high_side_drive}, {5'h0, hs});
    chk({7'h0, sense_stage, low_side_drive}, {7'h0, ss, ls});
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Pulse is one cycle wide, so keep what it named
  always @(posedge clk) begin
    if (status_clear_valid === 1'b1) begin
      clr_seen <= status_clear_request;
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      tally_and_finish;
    end
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    first_pwm_pin = 1'b0;
    second_pwm_pin = 1'b0;
    status_word = '{16'h8001, 16'h4c3a, 16'h2b56, 16'h1e0f};
    repeat (6) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    @(posedge clk);
    #1;
    outs(6'h00, 11'h000, 3'h0);
    frame(16'hfe00, status_word[0]);
    outs(6'h07, 11'h047, 3'h1);
    chk({13'h0, test_mode_bits}, 16'h0);
    frame(16'hffda, status_word[0]);
    outs(6'h3f, 11'h7ff, 3'h4);
    frame(16'hffa1, status_word[2]);
    outs(6'h38, 11'h03f, 3'h7);
    chk({15'h0, pullup_out7_enable}, 16'h1);
    first_pwm_pin = 1'b1;
    @(posedge clk);
    #1;
    outs(6'h3f, 11'h7ff, 3'h7);
    frame(16'hffef, status_word[1]);
    outs(6'h38, 11'h03f, 3'h0);
    chk({14'h0, pullup_out8_9_enable, pullup_out10_11_enable}, 16'h3);
    chk({14'h0, clr_seen}, 16'h1);
    second_pwm_pin = 1'b1;
    @(posedge clk);
    #1;
    outs(6'h3f, 11'h7ff, 3'h0);
    master.stray(4);
    outs(6'h3f, 11'h7ff, 3'h0);
    frame(16'h0000, status_word[3]);
    outs(6'h3f, 11'h7f8, 3'h1);
    tally_and_finish;
  end
endmodule
